// ### design/ebp_map.vh
// Constants for the external bus pin sequencer: interface codes, idle pin levels
// and widths.
// Assumes it is included by its bare name from the design and checker files.
`ifndef EBP_MAP_VH
`define EBP_MAP_VH

// ----------------------------------------------------------------------------
// Interface type codes, two bits per area in the area mode word
// ----------------------------------------------------------------------------
`define EBP_IF_W 2
`define EBP_IF_BASIC 2'h0
`define EBP_IF_SRAM 2'h1
`define EBP_IF_BROM 2'h2
`define EBP_IF_MUX 2'h3

// ----------------------------------------------------------------------------
// Sizes and default ratio of system clock to external bus clock
// ----------------------------------------------------------------------------
`define EBP_AREAS 8
`define EBP_AREA_W 3
`define EBP_DMA_CH 4
`define EBP_DMA_W 2
`define EBP_BCLK_DIV 8
`define EBP_PH_W 8
`define EBP_PH_ZERO 8'h00
`define EBP_PH_ONE 8'h01
`define EBP_SYNC_STAGES 2

// ----------------------------------------------------------------------------
// Pin levels
// ----------------------------------------------------------------------------
`define EBP_STB_OFF 1'b1
`define EBP_STB_ON 1'b0
`define EBP_DIR_READ 1'b1
`define EBP_DIR_WRITE 1'b0
`define EBP_LANE_UP 1
`define EBP_LANE_LO 0

`endif

// ### design/ebp_sync.v
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_sys; reset level is a parameter.
`timescale 1ns/1ns

module ebp_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // ----------------------------------------------------------------------------
  // The first stage feeds only the second stage.
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// ### design/ebp_bus_pins.v
// External bus pin sequencer: turns internal access requests into bus cycles.
// Assumes the area mode, two-state mask and pin enables are held steady by
// configuration logic, and that requests come from logic on clk_sys.
`timescale 1ns/1ns
`include "ebp_map.vh"

// How it works
// - Cycle start flag pulses low during the first bus state of every cycle.
// - Address strobe is low through basic, SRAM and burst ROM cycles.
// - In multiplexed space the same pin is low only in the address state.
// - Read strobe is low through every read, in all four space types.
// - Direction output is high for reads and low for writes.
// - In byte SRAM space the direction output serves as SRAM write enable.
// - Upper write strobe asserts when the upper lane is enabled; outside byte SRAM space only on a 16-bit bus.
// - Lower write strobe asserts only when the lower data lanes carry data.
// - In byte SRAM space both strobes act as byte selects, reads and writes.
// - Eight area selects, each asserted only while its own area is accessed.
// - Wait pin low stretches the access one bus clock at a time.
// - Release acknowledge goes low once the bus has been handed over.
// - While released, an internal request drives the return request low.
// - Each DMA channel gets its own acknowledge in single-address cycles.
// - Pins not enabled by ext_bus_en, bus16_mode or cs_pin_en stay undriven, like port inputs.
// - Area selects are active low.
// - Two-state areas ignore the wait pin.
// - Up to ratio sync cycles align a cycle to the bus clock.
module ebp_bus_pins #(
  parameter DIV = `EBP_BCLK_DIV
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ext_bus_en,
  input wire bus16_mode,
  input wire [`EBP_AREAS-1:0] cs_pin_en,
  input wire [`EBP_AREAS*`EBP_IF_W-1:0] area_mode,
  input wire [`EBP_AREAS-1:0] two_state,
  input wire wait_pin_enable,
  input wire acc_req,
  input wire [`EBP_AREA_W-1:0] acc_area,
  input wire acc_write,
  input wire [1:0] acc_be,
  input wire acc_dma_single,
  input wire [`EBP_DMA_W-1:0] acc_dma_ch,
  input wire wait_n,
  input wire bus_release_request_n,
  output reg acc_done_ff,
  output reg bus_clk_ff,
  output reg cycle_start_flag_n_ff,
  output reg addr_valid_strobe_n_ff,
  output reg rd_n_ff,
  output reg rd_wr_ff,
  output reg upper_write_strobe_n_ff,
  output reg lower_write_strobe_n_ff,
  output reg [`EBP_AREAS-1:0] area_select_n_ff,
  output reg bus_release_ack_n_ff,
  output reg bus_return_request_n_ff,
  output reg [`EBP_DMA_CH-1:0] dma_single_ack_n_ff,
  output reg ctrl_oe_ff,
  output reg upper_oe_ff,
  output reg [`EBP_AREAS-1:0] area_select_oe_ff
);

  // ----------------------------------------------------------------------------
  // States, one-hot
  // ----------------------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_SYNC = 7'h02;
  localparam [6:0] ST_T1 = 7'h04;
  localparam [6:0] ST_T2 = 7'h08;
  localparam [6:0] ST_T3 = 7'h10;
  localparam [6:0] ST_REL = 7'h20;
  localparam [6:0] ST_DONE = 7'h40;
  localparam [`EBP_PH_W-1:0] PH_LAST = DIV[`EBP_PH_W-1:0] - `EBP_PH_ONE;
  localparam [`EBP_PH_W-1:0] PH_HALF = DIV[`EBP_PH_W:1];

  reg [6:0] state_ff;
  reg [6:0] nxt_state;
  reg [`EBP_PH_W-1:0] ph_ff;
  reg [`EBP_PH_W-1:0] nxt_ph;
  reg [`EBP_AREA_W-1:0] area_ff;
  reg write_ff;
  reg [1:0] be_ff;
  reg dma_ff;
  reg [`EBP_DMA_W-1:0] dma_ch_ff;
  reg [`EBP_IF_W-1:0] if_ff;
  reg two_ff;
  wire [1:0] pins_sync;
  wire wait_req;
  wire bus_release_request;
  wire ph_end;
  wire in_cycle;
  wire pending;
  reg nxt_start;
  reg nxt_as;
  reg nxt_rd;
  reg nxt_dir;
  reg nxt_up;
  reg nxt_lo;
  reg nxt_sel;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  ebp_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({wait_n, bus_release_request_n}),
    .dout(pins_sync)
  );

  assign wait_req = wait_pin_enable & ~pins_sync[1] & ~two_ff;
  assign bus_release_request = ~pins_sync[0];
  assign ph_end = (ph_ff == PH_LAST);
  // A request is taken in the idle state only; the done cycle blocks a stale re-take.
  assign pending = acc_req & ~acc_done_ff & ext_bus_en;

  // ----------------------------------------------------------------------------
  // Bus clock phase counter; T1 and T2 each last one full bus clock period, T3 one or more while the wait pin holds it
  // ----------------------------------------------------------------------------
  always @* begin
    if (!ext_bus_en) begin
      nxt_ph = PH_LAST;
    end else if (ph_end) begin
      nxt_ph = `EBP_PH_ZERO;
    end else begin
      nxt_ph = ph_ff + `EBP_PH_ONE;
    end
  end

  // ----------------------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (ext_bus_en && bus_release_request) begin
          nxt_state = ST_REL;
        end else if (pending) begin
          nxt_state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (ph_end) begin
          nxt_state = ST_T1;
        end
      end
      ST_T1: begin
        if (ph_end) begin
          nxt_state = ST_T2;
        end
      end
      ST_T2: begin
        if (ph_end) begin
          nxt_state = two_ff ? ST_DONE : ST_T3;
        end
      end
      ST_T3: begin
        if (ph_end && !wait_req) begin
          nxt_state = ST_DONE;
        end
      end
      ST_REL: begin
        if (ph_end && !bus_release_request) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  assign in_cycle = (nxt_state == ST_T1) | (nxt_state == ST_T2) | (nxt_state == ST_T3);

  // ----------------------------------------------------------------------------
  // Next pin levels, taken from the next state so that they change together with
  // the rising bus clock edge
  // ----------------------------------------------------------------------------
  always @* begin
    nxt_start = `EBP_STB_OFF;
    nxt_as = `EBP_STB_OFF;
    nxt_rd = `EBP_STB_OFF;
    nxt_dir = `EBP_DIR_READ;
    nxt_up = `EBP_STB_OFF;
    nxt_lo = `EBP_STB_OFF;
    nxt_sel = 1'b0;
    if (in_cycle) begin
      nxt_sel = 1'b1;
      nxt_start = (nxt_state == ST_T1) ? `EBP_STB_ON : `EBP_STB_OFF;
      if (if_ff == `EBP_IF_MUX) begin
        nxt_as = (nxt_state == ST_T1) ? `EBP_STB_ON : `EBP_STB_OFF;
      end else begin
        nxt_as = `EBP_STB_ON;
      end
      nxt_rd = write_ff ? `EBP_STB_OFF : `EBP_STB_ON;
      nxt_dir = write_ff ? `EBP_DIR_WRITE : `EBP_DIR_READ;
      if (if_ff == `EBP_IF_SRAM) begin
        nxt_up = be_ff[`EBP_LANE_UP] ? `EBP_STB_ON : `EBP_STB_OFF;
        nxt_lo = be_ff[`EBP_LANE_LO] ? `EBP_STB_ON : `EBP_STB_OFF;
      end else if (write_ff && nxt_state != ST_T1) begin
        nxt_up = (be_ff[`EBP_LANE_UP] && bus16_mode) ? `EBP_STB_ON : `EBP_STB_OFF;
        nxt_lo = be_ff[`EBP_LANE_LO] ? `EBP_STB_ON : `EBP_STB_OFF;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State, request capture and shared pins
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      ph_ff <= PH_LAST;
      area_ff <= {`EBP_AREA_W{1'b0}};
      write_ff <= 1'b0;
      be_ff <= 2'h0;
      dma_ff <= 1'b0;
      dma_ch_ff <= {`EBP_DMA_W{1'b0}};
      if_ff <= `EBP_IF_BASIC;
      two_ff <= 1'b0;
      acc_done_ff <= 1'b0;
      bus_clk_ff <= 1'b0;
      cycle_start_flag_n_ff <= `EBP_STB_OFF;
      addr_valid_strobe_n_ff <= `EBP_STB_OFF;
      rd_n_ff <= `EBP_STB_OFF;
      rd_wr_ff <= `EBP_DIR_READ;
      upper_write_strobe_n_ff <= `EBP_STB_OFF;
      lower_write_strobe_n_ff <= `EBP_STB_OFF;
      bus_release_ack_n_ff <= `EBP_STB_OFF;
      bus_return_request_n_ff <= `EBP_STB_OFF;
      ctrl_oe_ff <= 1'b0;
      upper_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ph_ff <= nxt_ph;
      if (state_ff == ST_IDLE && nxt_state == ST_SYNC) begin
        area_ff <= acc_area;
        write_ff <= acc_write;
        be_ff <= acc_be;
        dma_ff <= acc_dma_single;
        dma_ch_ff <= acc_dma_ch;
        if_ff <= area_mode[acc_area*`EBP_IF_W +: `EBP_IF_W];
        two_ff <= two_state[acc_area];
      end
      acc_done_ff <= (nxt_state == ST_DONE);
      bus_clk_ff <= ext_bus_en & (nxt_ph < PH_HALF);
      cycle_start_flag_n_ff <= nxt_start;
      addr_valid_strobe_n_ff <= nxt_as;
      rd_n_ff <= nxt_rd;
      rd_wr_ff <= nxt_dir;
      upper_write_strobe_n_ff <= nxt_up;
      lower_write_strobe_n_ff <= nxt_lo;
      // Acknowledge on the same clock edge that the control pins are let go.
      bus_release_ack_n_ff <= (nxt_state == ST_REL) ? `EBP_STB_ON : `EBP_STB_OFF;
      bus_return_request_n_ff <= (nxt_state == ST_REL && acc_req) ?
                                 `EBP_STB_ON : `EBP_STB_OFF;
      // The bus clock keeps running while released; the strobes float.
      ctrl_oe_ff <= ext_bus_en & (nxt_state != ST_REL);
      upper_oe_ff <= ext_bus_en & bus16_mode & (nxt_state != ST_REL);
    end
  end

  // ----------------------------------------------------------------------------
  // Per-area selects and per-channel DMA acknowledges
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `EBP_AREAS; gi = gi + 1) begin : g_area
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          area_select_n_ff[gi] <= `EBP_STB_OFF;
          area_select_oe_ff[gi] <= 1'b0;
        end else begin
          area_select_n_ff[gi] <= (nxt_sel && area_ff == gi) ?
                                  `EBP_STB_ON : `EBP_STB_OFF;
          area_select_oe_ff[gi] <= ext_bus_en & cs_pin_en[gi] &
                                   (nxt_state != ST_REL);
        end
      end
    end
    for (gi = 0; gi < `EBP_DMA_CH; gi = gi + 1) begin : g_dack
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          dma_single_ack_n_ff[gi] <= `EBP_STB_OFF;
        end else begin
          dma_single_ack_n_ff[gi] <= (nxt_sel && dma_ff && dma_ch_ff == gi) ?
                                     `EBP_STB_ON : `EBP_STB_OFF;
        end
      end
    end
  endgenerate

endmodule

// ### verif/ebp_bus_pins_checker.sv
// Checker for the external bus pin sequencer ports.
// Assumes one clk_sys domain; bound onto every ebp_bus_pins instance.
`timescale 1ns/1ns
`include "ebp_map.vh"
module ebp_bus_pins_checker #(
  parameter int DIV = 8
) (
  input logic clk_sys,
  input logic rst_n,
  input logic ext_bus_en,
  input logic [15:0] area_mode,
  input logic [7:0] two_state,
  input logic wait_pin_enable,
  input logic acc_req,
  input logic [2:0] acc_area,
  input logic acc_write,
  input logic [1:0] acc_be,
  input logic wait_n,
  input logic acc_done_ff,
  input logic bus_clk_ff,
  input logic cycle_start_flag_n_ff,
  input logic addr_valid_strobe_n_ff,
  input logic rd_n_ff,
  input logic rd_wr_ff,
  input logic upper_write_strobe_n_ff,
  input logic lower_write_strobe_n_ff,
  input logic [7:0] area_select_n_ff,
  input logic bus_release_ack_n_ff,
  input logic bus_return_request_n_ff,
  input logic [3:0] dma_single_ack_n_ff,
  input logic ctrl_oe_ff
);
  // ---------------------------------------------------------------
  // Cycle length, counted from the first bus state
  // ---------------------------------------------------------------
  logic start_q_ff;
  logic two_ff;
  logic wseen_ff;
  logic [15:0] len_ff;
  wire first_state = !cycle_start_flag_n_ff && start_q_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_q_ff <= 1'h1;
      two_ff <= 1'h0;
      wseen_ff <= 1'h0;
      len_ff <= 16'h0;
    end else begin
      start_q_ff <= cycle_start_flag_n_ff;
      two_ff <= first_state ? two_state[acc_area] : two_ff;
      wseen_ff <= (wseen_ff && !first_state) || !wait_n;
      len_ff <= first_state ? 16'h1 : len_ff + 16'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_start;
    $fell(cycle_start_flag_n_ff);
  endsequence
  sequence s_held;
    (acc_req && !bus_release_ack_n_ff) [*2];
  endsequence
  chk_start_pins:
  assert property (s_start |-> $rose(bus_clk_ff) && !addr_valid_strobe_n_ff)
    else $error("cycle start off bus clock");
  chk_addr_hold:
  assert property (s_start |-> ##(DIV)
    (addr_valid_strobe_n_ff == (area_mode[acc_area*2 +: 2] == `EBP_IF_MUX)))
    else $error("address strobe wrong in second state");
  chk_dir_read:
  assert property (!rd_n_ff || !rd_wr_ff |-> rd_n_ff == acc_write && rd_wr_ff == !acc_write)
    else $error("read strobe or direction wrong");
  chk_byte_lanes:
  assert property ((upper_write_strobe_n_ff || acc_be[1]) && (lower_write_strobe_n_ff || acc_be[0]))
    else $error("lane strobe without lane");
  chk_one_select:
  assert property ($onehot0(~area_select_n_ff) && $onehot0(~dma_single_ack_n_ff))
    else $error("two selects at once");
  chk_idle_done:
  assert property (acc_done_ff |-> &{cycle_start_flag_n_ff, addr_valid_strobe_n_ff, rd_n_ff,
    rd_wr_ff, upper_write_strobe_n_ff, lower_write_strobe_n_ff, area_select_n_ff,
    dma_single_ack_n_ff})
    else $error("pins not idle at end");
  chk_release_ack:
  assert property (!bus_release_ack_n_ff |-> !ctrl_oe_ff && cycle_start_flag_n_ff)
    else $error("driving while released");
  chk_return_req:
  assert property (s_held |-> !bus_return_request_n_ff)
    else $error("no return request");
  chk_bclk_period:
  assert property ($rose(bus_clk_ff) && ext_bus_en |-> ##(DIV) $rose(bus_clk_ff))
    else $error("bus clock period wrong");
  chk_two_state:
  assert property (acc_done_ff && two_ff |-> len_ff == 2 * DIV)
    else $error("two-state length wrong");
  chk_three_state:
  assert property (acc_done_ff && !two_ff && (!wseen_ff || !wait_pin_enable) |->
    len_ff == 3 * DIV)
    else $error("three-state length wrong");
endmodule

bind ebp_bus_pins ebp_bus_pins_checker #(.DIV(DIV)) u_chk (.clk_sys, .rst_n, .ext_bus_en,
  .area_mode, .two_state, .wait_pin_enable, .acc_req, .acc_area, .acc_write, .acc_be,
  .wait_n, .acc_done_ff, .bus_clk_ff, .cycle_start_flag_n_ff, .addr_valid_strobe_n_ff,
  .rd_n_ff, .rd_wr_ff, .upper_write_strobe_n_ff, .lower_write_strobe_n_ff,
  .area_select_n_ff, .bus_release_ack_n_ff, .bus_return_request_n_ff,
  .dma_single_ack_n_ff, .ctrl_oe_ff);

// ### verif/ebp_far_side.sv
// Far-side model: a slow memory that stretches cycles, and another master.
// Assumes the testbench sets the wait length and the bus wish between cycles.
`timescale 1ns/1ns
module ebp_far_side #(
  parameter int DIV = 8
) (
  input logic clk_sys,
  input logic cycle_start_flag_n_ff,
  input int wait_bclks,
  input logic want_bus,
  output logic wait_n,
  output logic bus_release_request_n
);
  logic prev_ff = 1'h1;
  logic req_n_ff = 1'h1;
  int cnt_ff = 0;
  always @(posedge clk_sys) begin
    prev_ff <= cycle_start_flag_n_ff;
    req_n_ff <= !want_bus;
    if (prev_ff && !cycle_start_flag_n_ff) begin
      cnt_ff <= wait_bclks * DIV;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  // The wait pin has a pull-up, so it reads high once the part lets go.
  assign wait_n = cnt_ff == 0;
  assign bus_release_request_n = req_n_ff;
endmodule

// ### verif/ebp_bus_pins_tb.sv
// Testbench for the external bus pin sequencer with the far-side model.
// Assumes the checker is bound in and the bus clock runs at 160 ns.
`timescale 1ns/1ns
module ebp_bus_pins_tb;
  localparam int DIV = 8;
  logic clk_sys = 1'h0, rst_n = 1'h0, ext_bus_en = 1'h1, bus16_mode = 1'h1;
  logic wait_pin_enable = 1'h1, acc_req = 1'h0, acc_write = 1'h0, acc_dma_single = 1'h0;
  logic want_bus = 1'h0;
  logic [7:0] cs_pin_en = 8'hFF, two_state = 8'h00;
  logic [15:0] area_mode = 16'h00E4, seen;
  logic [2:0] acc_area = 3'h0;
  logic [1:0] acc_be = 2'h3, acc_dma_ch = 2'h0;
  int wait_bclks = 0, len, pre, miscompares = 0, n_tests = 0;
  wire wait_n, bus_release_request_n, acc_done_ff, bus_clk_ff, cycle_start_flag_n_ff;
  wire addr_valid_strobe_n_ff, rd_n_ff, rd_wr_ff, upper_write_strobe_n_ff, upper_oe_ff;
  wire lower_write_strobe_n_ff, bus_release_ack_n_ff, bus_return_request_n_ff, ctrl_oe_ff;
  wire [7:0] area_select_n_ff, area_select_oe_ff;
  wire [3:0] dma_single_ack_n_ff;
  ebp_bus_pins #(.DIV(DIV)) dut (.clk_sys, .rst_n, .ext_bus_en, .bus16_mode, .cs_pin_en,
    .area_mode, .two_state, .wait_pin_enable, .acc_req, .acc_area, .acc_write, .acc_be,
    .acc_dma_single, .acc_dma_ch, .wait_n, .bus_release_request_n, .acc_done_ff,
    .bus_clk_ff, .cycle_start_flag_n_ff, .addr_valid_strobe_n_ff, .rd_n_ff, .rd_wr_ff,
    .upper_write_strobe_n_ff, .lower_write_strobe_n_ff, .area_select_n_ff,
    .bus_release_ack_n_ff, .bus_return_request_n_ff, .dma_single_ack_n_ff, .ctrl_oe_ff,
    .upper_oe_ff, .area_select_oe_ff);
  ebp_far_side #(.DIV(DIV)) far (.clk_sys, .cycle_start_flag_n_ff, .wait_bclks,
    .want_bus, .wait_n, .bus_release_request_n);
  always #10 clk_sys = ~clk_sys;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Expected low-seen pins: selects, DMA acks, read, direction, upper, lower.
  function automatic logic [15:0] ex(input logic [2:0] a, input logic w,
      input logic [1:0] be, input logic dm, input logic [1:0] ch);
    logic sr;
    sr = area_mode[2*a +: 2] == 2'h1;
    return {~(8'h01 << a), dm ? ~(4'h1 << ch) : 4'hF, w, !w,
      !(be[1] && bus16_mode && (sr || w)), !(be[0] && (sr || w))};
  endfunction
  task automatic do_acc(input logic [2:0] a, input logic w, input logic [1:0] be,
      input logic dm, input logic [1:0] ch);
    bit on;
    on = 0;
    len = 0;
    pre = 0;
    seen = 16'hFFFF;
    @(posedge clk_sys);
    acc_req <= 1'h1;
    acc_area <= a;
    acc_write <= w;
    acc_be <= be;
    acc_dma_single <= dm;
    acc_dma_ch <= ch;
    repeat (400) begin
      @(posedge clk_sys);
      on |= !cycle_start_flag_n_ff;
      if (!on) pre++;
      if (on) seen &= {area_select_n_ff, dma_single_ack_n_ff, rd_n_ff, rd_wr_ff,
          upper_write_strobe_n_ff, lower_write_strobe_n_ff};
      if (acc_done_ff === 1'h1) break;
      if (on) len++;
    end
    chk("done", 1'h1, acc_done_ff);
    acc_req <= 1'h0;
  endtask
  task t_modes;
    for (int a = 0; a < 8; a++) begin
      for (int k = 0; k < 3; k++) begin
        do_acc(a[2:0], k != 0, 2'(3 - k), 1'h0, 2'h0);
        chk("pins", ex(a[2:0], k != 0, 2'(3 - k), 1'h0, 2'h0), seen);
        chk("length", 3 * DIV, len);
        chk("sync", 1'h1, pre >= 2 && pre <= DIV + 1);
      end
    end
  endtask
  task t_narrow;
    bus16_mode <= 1'h0;
    cs_pin_en <= 8'h0F;
    do_acc(3'h0, 1'h1, 2'h3, 1'h0, 2'h0);
    chk("narrow", ex(3'h0, 1'h1, 2'h3, 1'h0, 2'h0), seen);
    chk("upper oe", 1'h0, upper_oe_ff);
    chk("select oe", 8'h0F, area_select_oe_ff);
    bus16_mode <= 1'h1;
    cs_pin_en <= 8'hFF;
  endtask
  task t_dma;
    for (int c = 0; c < 4; c++) begin
      do_acc(3'h5, 1'h0, 2'h3, 1'h1, c[1:0]);
      chk("dma", ex(3'h5, 1'h0, 2'h3, 1'h1, c[1:0]), seen);
    end
  endtask
  task t_wait;
    wait_bclks <= 4;
    two_state <= 8'h01;
    do_acc(3'h0, 1'h0, 2'h3, 1'h0, 2'h0);
    chk("two-state", 2 * DIV, len);
    two_state <= 8'h00;
    do_acc(3'h4, 1'h1, 2'h3, 1'h0, 2'h0);
    chk("waited", 1'h1, len > 3 * DIV && len % DIV == 0);
    wait_pin_enable <= 1'h0;
    do_acc(3'h4, 1'h1, 2'h3, 1'h0, 2'h0);
    chk("wait off", 3 * DIV, len);
    wait_pin_enable <= 1'h1;
    wait_bclks <= 0;
  endtask
  task t_release;
    want_bus <= 1'h1;
    repeat (8) @(posedge clk_sys);
    chk("ack", 1'h0, bus_release_ack_n_ff);
    chk("oe", 1'h0, ctrl_oe_ff);
    fork
      do_acc(3'h2, 1'h0, 2'h3, 1'h0, 2'h0);
      begin
        repeat (8) @(posedge clk_sys);
        chk("return", 1'h0, bus_return_request_n_ff);
        chk("held", 0, len);
        want_bus <= 1'h0;
      end
    join
    chk("after", 3 * DIV, len);
  endtask
  task stop_test;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_modes;
    t_narrow;
    t_dma;
    t_wait;
    t_release;
    stop_test;
  end
  initial begin
    #(20 * 6000);
    miscompares++;
    stop_test;
  end
endmodule
